// file: fms_sequencer.sv
/*
 * Freeze mode sequencer: drives the processor reset and freeze pins to put the
 * processor into freeze mode and to bring it back through a full reset.
 * Assumes an external settle timer answers the start output on timer_done,
 * and that the board reset rst_n is asynchronous and active low.
 */
// Behaviour
// [R01] Idle: enter request alone starts freeze steps
// [R02] Idle: exit request wins, go to wait
// [R03] Wait: reset low, freeze high, start high
// [R04] Timer starts on start, reports done
// [R05] Settle delay lasts ten thousand processor clocks
// [R06] Freeze: sixteen steps, then reset released with freeze held low
// [R07] Recover: sixteen reset steps, then idle
// [R08] Step counter 0..15, else zero
// [R09] Board reset also resets the processor
// [R10] Registered outputs; reset returns idle state
// [R11] Processor samples freeze low across reset release
`timescale 1ns/100ps
module fms_sequencer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enter_freeze_request,
    input wire logic exit_freeze_request,
    input wire logic timer_done,
    output logic cpu_reset_n,
    output logic cpu_freeze_n,
    output logic timer_start,
    output logic [3:0] step
);
    // ****************************************
    // Input synchronisation
    // ****************************************
    fms_sync_if sync_bus ();
    logic [2:0] sync_level;

    fms_input_sync #(.WIDTH(3)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .raw({timer_done, exit_freeze_request, enter_freeze_request}),
        .level(sync_level)
    );

    assign sync_bus.enter = sync_level[0];
    assign sync_bus.exit_req = sync_level[1];
    assign sync_bus.done = sync_level[2];

    // ****************************************
    // State transitions
    // ****************************************
    fms_pkg::fms_state_type state;
    fms_pkg::fms_state_type next_state;
    logic [3:0] next_step;
    wire step_end = (step == fms_pkg::FMS_STEP_LAST);

    always_comb begin
        next_state = state;
        next_step = fms_pkg::FMS_STEP_RESET;
        case (state)
            fms_pkg::FMS_IDLE: begin
                if (sync_bus.exit_req) begin
                    next_state = fms_pkg::FMS_WAIT; // [R02]
                end else if (sync_bus.enter) begin
                    next_state = fms_pkg::FMS_FREEZE; // [R01]
                end
            end
            fms_pkg::FMS_WAIT: begin
                if (sync_bus.done) begin
                    next_state = fms_pkg::FMS_RECOVER; // [R03] [R04]
                end
            end
            fms_pkg::FMS_FREEZE: begin
                if (step_end) begin
                    next_state = fms_pkg::FMS_FREEZE_LAST; // [R06]
                end else begin
                    next_step = step + 4'h1; // [R08]
                end
            end
            fms_pkg::FMS_FREEZE_LAST: begin
                next_state = fms_pkg::FMS_IDLE; // [R06]
            end
            fms_pkg::FMS_RECOVER: begin
                if (step_end) begin
                    next_state = fms_pkg::FMS_IDLE; // [R07]
                end else begin
                    next_step = step + 4'h1; // [R08]
                end
            end
            default: begin
                next_state = fms_pkg::FMS_IDLE;
            end
        endcase
    end

    // ****************************************
    // Output decode (Moore)
    // ****************************************
    wire next_reset_n = (next_state == fms_pkg::FMS_IDLE)
        || (next_state == fms_pkg::FMS_FREEZE_LAST); // [R06] [R07]
    wire next_freeze_n = (next_state != fms_pkg::FMS_FREEZE)
        && (next_state != fms_pkg::FMS_FREEZE_LAST); // [R06] [R11]
    wire next_start = (next_state == fms_pkg::FMS_WAIT); // [R03]

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= fms_pkg::FMS_IDLE; // [R10]
            step <= fms_pkg::FMS_STEP_RESET;
            cpu_reset_n <= fms_pkg::FMS_RESET_N_RESET; // [R09]
            cpu_freeze_n <= fms_pkg::FMS_FREEZE_N_RESET;
            timer_start <= fms_pkg::FMS_START_RESET;
        end else begin
            state <= next_state;
            step <= next_step;
            cpu_reset_n <= next_reset_n;
            cpu_freeze_n <= next_freeze_n;
            timer_start <= next_start;
        end
    end
endmodule

// file: fms_pkg.sv
/*
 * Constants of the freeze mode sequencer: state codes, step counts, output levels.
 * Assumes a single system clock and an active-low asynchronous board reset.
 */
package fms_pkg;
    // One-hot state codes
    typedef enum logic [4:0] {
        FMS_IDLE = 5'h01,
        FMS_WAIT = 5'h02,
        FMS_FREEZE = 5'h04,
        FMS_FREEZE_LAST = 5'h08,
        FMS_RECOVER = 5'h10
    } fms_state_type;

    localparam int FMS_STEP_WIDTH = 4;
    localparam logic [3:0] FMS_STEP_LAST = 4'hF;
    localparam logic [3:0] FMS_STEP_RESET = 4'h0;
    localparam logic FMS_RESET_N_RESET = 1'b0;
    localparam logic FMS_FREEZE_N_RESET = 1'b1;
    localparam logic FMS_START_RESET = 1'b0;
endpackage

// file: fms_sync_if.sv
/*
 * Carries synchronised request levels from the input stage to the sequencer.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/100ps
interface fms_sync_if;
    logic enter;
    logic exit_req;
    logic done;
    modport source (output enter, exit_req, done);
    modport sink (input enter, exit_req, done);
endinterface

// file: fms_input_sync.sv
/*
 * Three-stage synchroniser for the asynchronous request and timer inputs.
 * Assumes inputs come from pins outside the clock domain; a level counts once
 * the second and third stages agree.
 */
`timescale 1ns/100ps
module fms_input_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                    stage3[i] <= 1'b0;
                    level[i] <= 1'b0;
                end else begin
                    stage1[i] <= raw[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    if (stage2[i] == stage3[i]) begin
                        level[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate
endmodule

// file: fms_timer_model.sv
/* Settle timer model for the sequencer bench.
 * Assumes timer_start stays high until timer_done is seen. */
`timescale 1ns/100ps
module fms_timer_model #(
    parameter int DELAY = 10000
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic timer_start,
    output logic timer_done
);
    int count;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) count <= 0;
        else count <= timer_start ? count + 1 : 0;
    end
    assign timer_done = timer_start && count >= DELAY;
endmodule

// file: fms_chk.sv
/* Port checker for fms_sequencer.
 * Assumes one clock and the active-low board reset. */
`timescale 1ns/100ps
module fms_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enter_freeze_request,
    input wire logic exit_freeze_request,
    input wire logic timer_done,
    input wire logic cpu_reset_n,
    input wire logic cpu_freeze_n,
    input wire logic timer_start,
    input wire logic [3:0] step
);
    wire logic idle = cpu_reset_n && cpu_freeze_n;
    wire logic [6:0] o = {cpu_reset_n, cpu_freeze_n, timer_start, step};
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    wait_out_a: assert property (timer_start |-> o == 7'h30) else $error("wait");
    idle_out_a: assert property (idle |-> o == 7'h60) else $error("idle");
    step_inc_a: assert property (step != 4'h0 |-> step == $past(step) + 4'h1) else $error("step");
    frz_seq_a: assert property ($fell(cpu_freeze_n) |-> o == 7'h00 ##15 o == 7'h0F
        ##1 o == 7'h40 ##1 idle) else $error("freeze");
    rec_seq_a: assert property ($fell(timer_start) |-> o == 7'h20 ##15 o == 7'h2F
        ##1 idle) else $error("recover");
    enter_go_a: assert property ((idle && enter_freeze_request && !exit_freeze_request)[*4]
        |-> ##[1:4] !cpu_freeze_n) else $error("enter");
    exit_go_a: assert property ((idle && exit_freeze_request)[*4] |-> ##[1:4] timer_start)
        else $error("exit");
    done_go_a: assert property ((timer_start && timer_done)[*5] |-> ##[1:3] !timer_start)
        else $error("done");
    wait_hold_a: assert property (timer_start && !timer_done |=> timer_start)
        else $error("wait left early");
    frz_hold_a: assert property (!cpu_reset_n && !cpu_freeze_n |=> !cpu_freeze_n)
        else $error("freeze released with reset");
    cover property ($fell(cpu_freeze_n));
    cover property ($fell(timer_start));
    cover property (step == 4'hF);
endmodule
bind fms_sequencer fms_chk chk (.clock(clock), .rst_n(rst_n),
    .enter_freeze_request(enter_freeze_request), .exit_freeze_request(exit_freeze_request),
    .timer_done(timer_done), .cpu_reset_n(cpu_reset_n), .cpu_freeze_n(cpu_freeze_n),
    .timer_start(timer_start), .step(step));

// file: tb_top.sv
/* Bench for fms_sequencer with the settle timer model.
 * Assumes the timer model keeps the full settle delay. */
`timescale 1ns/100ps
module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic enter_freeze_request = 1'b0;
    logic exit_freeze_request = 1'b0;
    logic timer_done, cpu_reset_n, cpu_freeze_n, timer_start;
    logic [3:0] step;
    localparam int TIMER_DELAY = 10000;
    localparam int TIMEOUT_CYCLES = 12000;
    int mismatches = 0, compares = 0, cycles = 0;
    wire logic [6:0] o = {cpu_reset_n, cpu_freeze_n, timer_start, step};
    fms_sequencer dut (.clock(clock), .rst_n(rst_n), .enter_freeze_request(enter_freeze_request),
        .exit_freeze_request(exit_freeze_request), .timer_done(timer_done),
        .cpu_reset_n(cpu_reset_n), .cpu_freeze_n(cpu_freeze_n), .timer_start(timer_start),
        .step(step));
    fms_timer_model #(.DELAY(TIMER_DELAY)) timer (.clock(clock), .rst_n(rst_n),
        .timer_start(timer_start), .timer_done(timer_done));
    initial forever #2.5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYCLES) begin
            mismatches++;
            final_report;
        end
    end
    task chk(input logic [6:0] seen, input logic [6:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task run_seq(input logic [6:0] base, input int n);
        for (int k = 0; k < n; k++) begin
            chk(o, k < 16 ? base | 7'(k) : (k == n - 1 ? 7'h60 : 7'h40));
            @(posedge clock) {enter_freeze_request, exit_freeze_request} <= 2'h0;
            @(negedge clock);
        end
    endtask
    task t_enter;
        @(posedge clock) enter_freeze_request <= 1'b1;
        for (int i = 0; i < 9 && cpu_freeze_n !== 1'b0; i++) @(negedge clock);
        run_seq(7'h00, 18);
    endtask
    task t_exit;
        int n;
        n = 0;
        @(posedge clock) {enter_freeze_request, exit_freeze_request} <= 2'h3;
        for (int i = 0; i < 9 && timer_start !== 1'b1; i++) @(negedge clock);
        while (n < TIMER_DELAY + 60 && timer_start === 1'b1) begin
            chk(o, 7'h30);
            n++;
            @(posedge clock) {enter_freeze_request, exit_freeze_request} <= 2'h0;
            @(negedge clock);
        end
        chk(7'(n - TIMER_DELAY), 7'h05);
        run_seq(7'h20, 17);
    endtask
    task t_reset;
        @(posedge clock) enter_freeze_request <= 1'b1;
        repeat (10) @(posedge clock);
        rst_n <= 1'b0;
        enter_freeze_request <= 1'b0;
        @(negedge clock) chk(o, 7'h20);
        @(posedge clock) rst_n <= 1'b1;
        @(posedge clock);
        @(negedge clock) chk(o, 7'h60);
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(negedge clock);
        t_enter;
        t_exit;
        t_reset;
        final_report;
    end
endmodule
